// ### hdl/pls_pkg.sv
/*
  Constants for the management status register block: register map,
  bit layout, frame field lengths, reset values and the frame states.
  Assumes one synchronous clock domain in the importing modules.
*/
package pls_pkg;

  // ----------------------------------------
  // Register map and frame codes
  // ----------------------------------------
  localparam logic [4:0] PLS_REG_STATUS = 5'h01;
  localparam logic [1:0] PLS_OP_READ = 2'h2;
  localparam logic [1:0] PLS_OP_WRITE = 2'h1;
  localparam int PLS_DATA_W = 16;
  localparam int PLS_ADDR_W = 10;
  localparam int PLS_SYNC_W = 2;

  // ----------------------------------------
  // Field lengths, as last count value
  // ----------------------------------------
  localparam logic [3:0] PLS_CNT_ZERO = 4'h0;
  localparam logic [3:0] PLS_CNT_OP = 4'h1;
  localparam logic [3:0] PLS_CNT_ADDR = 4'h9;
  localparam logic [3:0] PLS_CNT_TA = 4'h1;
  localparam logic [3:0] PLS_CNT_DATA = 4'hF;
  localparam logic [3:0] PLS_CNT_ONE = 4'h1;

  // ----------------------------------------
  // Status word bit positions
  // ----------------------------------------
  localparam int PLS_B_T4 = 15;
  localparam int PLS_B_FD100 = 14;
  localparam int PLS_B_HD100 = 13;
  localparam int PLS_B_FD10 = 12;
  localparam int PLS_B_HD10 = 11;
  localparam int PLS_B_T2 = 10;
  localparam int PLS_B_RSV_HI = 9;
  localparam int PLS_B_RSV_LO = 7;
  localparam int PLS_B_NOPRE = 6;
  localparam int PLS_B_ANDONE = 5;
  localparam int PLS_B_RFAULT = 4;
  localparam int PLS_B_ANABLE = 3;
  localparam int PLS_B_LINK = 2;
  localparam int PLS_B_JABBER = 1;
  localparam int PLS_B_EXTCAP = 0;

  // ----------------------------------------
  // Fixed values and reset values
  // ----------------------------------------
  localparam logic PLS_CAP_YES = 1'h1;
  localparam logic PLS_CAP_NO = 1'h0;
  localparam logic [2:0] PLS_RSV_VAL = 3'h0;
  localparam logic PLS_LATCH_RST = 1'h0;
  localparam logic PLS_AN_RST = 1'h0;
  localparam logic [PLS_DATA_W-1:0] PLS_WORD_RST = 16'h0000;
  localparam logic [PLS_ADDR_W-1:0] PLS_ADDR_RST = 10'h000;
  localparam logic [4:0] PLS_PHY_RST = 5'h00;

  // ----------------------------------------
  // Frame states, Gray along the frame path
  // ----------------------------------------
  typedef enum logic [2:0] {
    PLS_S_HUNT = 3'h0,
    PLS_S_IDLE = 3'h1,
    PLS_S_START = 3'h3,
    PLS_S_OP = 3'h2,
    PLS_S_ADDR = 3'h6,
    PLS_S_TA = 3'h7,
    PLS_S_DATA = 3'h5
  } pls_state_t;

endpackage : pls_pkg

// ### hdl/pls_status.sv
/*
  Status register of a 10/100 PHY behind the serial management port.
  Decodes management frames on the clock/data pins, answers reads of
  the status register and of any other register (zero), ignores writes.
  Assumes the link, autonegotiation and jabber levels come from logic
  on the same clock, and management pins come from outside.
*/
// Operation
// - Bit 15 (four-pair 100 Mbit/s ability) always reads 0.
// - Bits 14 to 11 always read 1 for the four 100/10 full/half duplex abilities.
// - Bit 10 (two-pair 100 Mbit/s ability) always reads 0.
// - Bit 5 shows autonegotiation complete while it is enabled, and resets to 0.
// - Bit 4 latches to 1 on partner remote fault or far-end fault.
// - A status read releases the remote fault latch.
// - Bit 3 always reads 1 for autonegotiation ability.
// - Bit 2 follows the link state, 1 up and 0 down.
// - Reset or loss of link latches bit 2 at 0 until the register is read.
// - In 10 Mbit/s mode a jabber sets bit 1 until the register is read.
// - Bit 0 always reads 1 for the extended register set.
// - Latched high bits stay 1 until a read of their register.
`timescale 1ns/1ns
module pls_status
  import pls_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // Address strap
  input wire logic [4:0] phy_addr,
  // Line conditions
  input wire logic link_ok,
  input wire logic an_enable,
  input wire logic an_complete,
  input wire logic partner_remote_fault_flag,
  input wire logic far_end_fault,
  input wire logic jabber,
  input wire logic speed_10
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [PLS_SYNC_W-1:0] pins_s;
  logic mdc_q_r;
  logic mdc_rise;
  logic mdio_bit;

  pls_sync #(.W(PLS_SYNC_W)) u_sync (
    .clock(clock),
    .rst(rst),
    .din({mdc, mdio_i}),
    .dout(pins_s)
  );

  assign mdio_bit = pins_s[0];
  assign mdc_rise = pins_s[1] & ~mdc_q_r;

  always_ff @(posedge clock)
  begin
    if (rst)
      mdc_q_r <= PLS_CAP_YES;
    else
      mdc_q_r <= pins_s[1];
  end

  // ----------------------------------------
  // Address strap, caught during reset
  // ----------------------------------------
  logic [4:0] phy_r;

  always_ff @(posedge clock)
  begin
    if (rst)
      phy_r <= phy_addr;
  end

  // ----------------------------------------
  // Frame decoder
  // ----------------------------------------
  pls_state_t state_r;
  pls_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [1:0] op_r;
  logic [PLS_ADDR_W-1:0] addr_r;
  logic rd_match;
  logic load;
  logic rd_evt;

  assign rd_match = (op_r == PLS_OP_READ) && (addr_r[PLS_ADDR_W-1:5] == phy_r);
  assign load = mdc_rise && (state_r == PLS_S_TA) && (cnt_r == PLS_CNT_ZERO) && rd_match;
  assign rd_evt = load && (addr_r[4:0] == PLS_REG_STATUS);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (mdc_rise)
    begin
      cnt_nxt = cnt_r + PLS_CNT_ONE;
      unique case (state_r)
        PLS_S_HUNT:
        begin
          if (mdio_bit)
            state_nxt = PLS_S_IDLE;
        end
        PLS_S_IDLE:
        begin
          cnt_nxt = PLS_CNT_ZERO;
          if (!mdio_bit)
            state_nxt = PLS_S_START;
        end
        PLS_S_START:
        begin
          cnt_nxt = PLS_CNT_ZERO;
          state_nxt = mdio_bit ? PLS_S_OP : PLS_S_HUNT;
        end
        PLS_S_OP:
        begin
          if (cnt_r == PLS_CNT_OP)
          begin
            cnt_nxt = PLS_CNT_ZERO;
            state_nxt = PLS_S_ADDR;
          end
        end
        PLS_S_ADDR:
        begin
          if (cnt_r == PLS_CNT_ADDR)
          begin
            cnt_nxt = PLS_CNT_ZERO;
            state_nxt = PLS_S_TA;
          end
        end
        PLS_S_TA:
        begin
          if (cnt_r == PLS_CNT_TA)
          begin
            cnt_nxt = PLS_CNT_ZERO;
            state_nxt = PLS_S_DATA;
          end
        end
        PLS_S_DATA:
        begin
          if (cnt_r == PLS_CNT_DATA)
            state_nxt = PLS_S_HUNT;
        end
        default:
          state_nxt = PLS_S_HUNT;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= PLS_S_HUNT;
      cnt_r <= PLS_CNT_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      op_r <= PLS_OP_WRITE;
      addr_r <= PLS_ADDR_RST;
    end
    else if (mdc_rise && state_r == PLS_S_OP)
      op_r <= {op_r[0], mdio_bit};
    else if (mdc_rise && state_r == PLS_S_ADDR)
      addr_r <= {addr_r[PLS_ADDR_W-2:0], mdio_bit};
  end

  // ----------------------------------------
  // Live and latched status
  // ----------------------------------------
  logic an_done_r;
  logic rf_lh_r;
  logic link_ll_r;
  logic jab_lh_r;
  logic rf_cond;
  logic jab_cond;

  assign rf_cond = partner_remote_fault_flag | far_end_fault;
  assign jab_cond = jabber & speed_10;

  always_ff @(posedge clock)
  begin
    if (rst)
      an_done_r <= PLS_AN_RST;
    else
      an_done_r <= an_enable & an_complete;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rf_lh_r <= PLS_LATCH_RST;
      jab_lh_r <= PLS_LATCH_RST;
    end
    else
    begin
      rf_lh_r <= rf_cond | (rf_lh_r & ~rd_evt);
      jab_lh_r <= jab_cond | (jab_lh_r & ~rd_evt);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      link_ll_r <= PLS_LATCH_RST;
    else
      link_ll_r <= link_ok & (link_ll_r | rd_evt);
  end

  // ----------------------------------------
  // Status word and read shifter
  // ----------------------------------------
  logic [PLS_DATA_W-1:0] status_word;
  logic [PLS_DATA_W-1:0] shift_r;
  logic mdio_o_r;
  logic mdio_oe_r;

  always_comb
  begin
    status_word = PLS_WORD_RST;
    status_word[PLS_B_T4] = PLS_CAP_NO;
    status_word[PLS_B_FD100] = PLS_CAP_YES;
    status_word[PLS_B_HD100] = PLS_CAP_YES;
    status_word[PLS_B_FD10] = PLS_CAP_YES;
    status_word[PLS_B_HD10] = PLS_CAP_YES;
    status_word[PLS_B_T2] = PLS_CAP_NO;
    status_word[PLS_B_RSV_HI:PLS_B_RSV_LO] = PLS_RSV_VAL;
    status_word[PLS_B_NOPRE] = PLS_CAP_YES;
    status_word[PLS_B_ANDONE] = an_done_r;
    status_word[PLS_B_RFAULT] = rf_lh_r;
    status_word[PLS_B_ANABLE] = PLS_CAP_YES;
    status_word[PLS_B_LINK] = link_ll_r;
    status_word[PLS_B_JABBER] = jab_lh_r;
    status_word[PLS_B_EXTCAP] = PLS_CAP_YES;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      shift_r <= PLS_WORD_RST;
    else if (load)
      shift_r <= rd_evt ? status_word : PLS_WORD_RST;
    else if (mdc_rise && state_r == PLS_S_DATA)
      shift_r <= {shift_r[PLS_DATA_W-2:0], PLS_CAP_NO};
  end

  // Pin drive; write frames never drive and change nothing
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mdio_o_r <= PLS_CAP_YES;
      mdio_oe_r <= PLS_CAP_NO;
    end
    else if (load)
    begin
      mdio_o_r <= PLS_CAP_NO;
      mdio_oe_r <= PLS_CAP_YES;
    end
    else if (mdc_rise && state_r == PLS_S_TA && mdio_oe_r)
      mdio_o_r <= shift_r[PLS_DATA_W-1];
    else if (mdc_rise && state_r == PLS_S_DATA && mdio_oe_r)
    begin
      mdio_o_r <= shift_r[PLS_DATA_W-2];
      if (cnt_r == PLS_CNT_DATA)
      begin
        mdio_o_r <= PLS_CAP_YES;
        mdio_oe_r <= PLS_CAP_NO;
      end
    end
  end

  assign mdio_o = mdio_o_r;
  assign mdio_oe = mdio_oe_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_status_load;
    rd_evt;
  endsequence

  sequence s_turn_drive;
    mdio_oe_r && !mdio_o_r;
  endsequence

  a_t4_absent: assert property (s_status_load |=> !shift_r[PLS_B_T4])
    else $error("four-pair ability not zero");
  a_speed_caps: assert property (s_status_load |=> shift_r[PLS_B_FD100:PLS_B_HD10] == 4'hF)
    else $error("speed abilities not all one");
  a_t2_absent: assert property (s_status_load |=> !shift_r[PLS_B_T2])
    else $error("two-pair ability not zero");
  a_no_preamble: assert property (s_status_load |=> shift_r[PLS_B_NOPRE] ##0 s_turn_drive)
    else $error("preamble suppression bit or turnaround wrong");
  a_an_done: assert property (##1 an_done_r == $past(an_enable && an_complete))
    else $error("autonegotiation complete mismatch");
  a_rf_latch: assert property (rf_cond |=> rf_lh_r)
    else $error("remote fault not latched");
  a_rf_release: assert property ((rd_evt && !rf_cond) |=> !rf_lh_r)
    else $error("remote fault not released by read");
  a_an_able: assert property (s_status_load |=> shift_r[PLS_B_ANABLE])
    else $error("autonegotiation ability not one");
  a_link_down: assert property (!link_ok |=> !link_ll_r)
    else $error("link bit not down");
  a_link_hold: assert property ((!link_ll_r && !rd_evt) |=> !link_ll_r)
    else $error("link low latch released without read");
  a_jab_latch: assert property ((jabber && speed_10) |=> jab_lh_r)
    else $error("jabber not latched");
  a_ext_cap: assert property (s_status_load |=> shift_r[PLS_B_EXTCAP])
    else $error("extended capability not one");
  a_lh_hold: assert property ((jab_lh_r && !rd_evt) |=> jab_lh_r [*2] or rd_evt)
    else $error("jabber latch dropped without read");
  a_rsv_zero: assert property (load |=> shift_r[PLS_B_RSV_HI:PLS_B_RSV_LO] == PLS_RSV_VAL)
    else $error("reserved bits not zero");
  a_relatch: assert property ((rd_evt && rf_cond) |=> rf_lh_r)
    else $error("remote fault not set again");

endmodule : pls_status

// ### hdl/pls_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; output changes only when stages two and
  three agree.
*/
`timescale 1ns/1ns
module pls_sync
  import pls_pkg::*;
#(
  parameter int W = PLS_SYNC_W
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Raw and filtered levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          s1_r <= PLS_CAP_YES;
          s2_r <= PLS_CAP_YES;
          s3_r <= PLS_CAP_YES;
          out_r <= PLS_CAP_YES;
        end
        else
        begin
          s1_r <= din[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
          begin
            out_r <= s3_r;
          end
        end
      end
      assign dout[i] = out_r;
    end
  endgenerate

endmodule : pls_sync

// ### verification/pls_mgmt_model.sv
/*
  Station management controller model: sends management frames on the
  clock and data pins and collects the read data word.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ns
module pls_mgmt_model
  import pls_pkg::*;
(
  // Clock
  input wire logic clock,
  // Management pins
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en,
  input wire logic mdio_line,
  // Read result
  output logic rd_done,
  output logic [PLS_DATA_W-1:0] rd_word
);
  localparam int HALF = 8;

  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_en = 1'b0;
    rd_done = 1'b0;
    rd_word = 16'h0000;
  end

  // ----------------------------------------
  // One bit: set data, rise, sample, hold
  // ----------------------------------------
  task automatic bit_cycle(input logic drv, input logic val, output logic smp);
    mdc = 1'b0;
    mdio_en = drv;
    mdio_drv = val;
    repeat (HALF) @(posedge clock);
    #1;
    mdc = 1'b1;
    smp = mdio_line;
    repeat (HALF) @(posedge clock);
    #1;
  endtask : bit_cycle

  // ----------------------------------------
  // Whole frame, optional preamble
  // ----------------------------------------
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic [31:0] f;
    logic s;
    logic [15:0] r;
    logic rd;
    rd = (op == PLS_OP_READ);
    r = 16'h0000;
    f = {2'h1, op, pa, ra, 2'h2, wd};
    repeat (pre) bit_cycle(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      bit_cycle(!(rd && i < 18), f[i], s);
      if (i < 16)
        r = {r[14:0], s};
    end
    bit_cycle(1'b1, 1'b1, s);
    mdc = 1'b0;
    mdio_en = 1'b0;
    rd_word = r;
    rd_done = rd;
    @(posedge clock);
    #1;
    rd_done = 1'b0;
  endtask : frame
endmodule : pls_mgmt_model

// ### verification/tb_top.sv
/*
  Self-checking bench for the status register block: reads, writes and
  latch scenarios over the management pins, results checked from a queue.
  Assumes a pull-up on the management data line.
*/
`timescale 1ns/1ns
module tb_top;
  import pls_pkg::*;
  localparam logic [15:0] BASE = 16'h7849;
  logic clock, rst, mdc, mdio_i, mdio_o, mdio_oe, mdio_drv, mdio_en, rd_done, quiet;
  logic [4:0] phy_addr;
  logic link_ok, an_enable, an_complete, partner_remote_fault_flag, far_end_fault, jabber, speed_10;
  logic [15:0] rd_word;
  logic [15:0] exp_q[$];
  int fails, num_checks;

  assign mdio_i = mdio_oe ? mdio_o : (mdio_en ? mdio_drv : 1'b1);

  pls_status i_dut (.clock(clock), .rst(rst), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .phy_addr(phy_addr), .link_ok(link_ok), .an_enable(an_enable),
    .an_complete(an_complete), .partner_remote_fault_flag(partner_remote_fault_flag),
    .far_end_fault(far_end_fault), .jabber(jabber), .speed_10(speed_10));

  pls_mgmt_model i_mgmt (.clock(clock), .mdc(mdc), .mdio_drv(mdio_drv), .mdio_en(mdio_en),
    .mdio_line(mdio_i), .rd_done(rd_done), .rd_word(rd_word));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------
  // Compare, report and end of run
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle

  task automatic rd(input int pre, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
    exp_q.push_back(exp);
    i_mgmt.frame(pre, PLS_OP_READ, pa, ra, 16'h0000);
  endtask : rd

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (rd_done === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'h0001, 16'h0000);
      else
        check(rd_word, exp_q.pop_front());
    end
  end

  always @(negedge clock)
  begin
    if (quiet)
      check({15'h0000, mdio_oe}, 16'h0000);
  end

  initial
  begin
    repeat (100000) @(posedge clock);
    fails++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] a;
    logic s;
    fails = 0;
    num_checks = 0;
    quiet = 1'b0;
    rst = 1'b1;
    link_ok = 1'b1;
    {an_enable, an_complete, partner_remote_fault_flag, far_end_fault, jabber, speed_10} = 6'h00;
    a = $urandom(92803);
    phy_addr = 5'($urandom);
    repeat (5) @(posedge clock);
    #1;
    rst = 1'b0;
    idle(6);
    rd(32, phy_addr, PLS_REG_STATUS, BASE);
    rd(0, phy_addr, PLS_REG_STATUS, BASE | 16'h0004);
    link_ok = 1'b0;
    idle(3);
    link_ok = 1'b1;
    idle(3);
    rd(0, phy_addr, PLS_REG_STATUS, BASE);
    rd(0, phy_addr, PLS_REG_STATUS, BASE | 16'h0004);
    for (int k = 0; k < 2; k++)
    begin
      partner_remote_fault_flag = (k == 0);
      far_end_fault = (k == 1);
      idle(2);
      {partner_remote_fault_flag, far_end_fault} = 2'h0;
      idle(2);
      rd(0, phy_addr, PLS_REG_STATUS, 16'h785D);
      rd(0, phy_addr, PLS_REG_STATUS, 16'h784D);
    end
    far_end_fault = 1'b1;
    rd(0, phy_addr, PLS_REG_STATUS, 16'h785D);
    rd(0, phy_addr, PLS_REG_STATUS, 16'h785D);
    far_end_fault = 1'b0;
    rd(0, phy_addr, PLS_REG_STATUS, 16'h785D);
    rd(0, phy_addr, PLS_REG_STATUS, 16'h784D);
    speed_10 = 1'b1;
    jabber = 1'b1;
    idle(1);
    jabber = 1'b0;
    rd(0, phy_addr, PLS_REG_STATUS, 16'h784F);
    rd(0, phy_addr, PLS_REG_STATUS, 16'h784D);
    speed_10 = 1'b0;
    jabber = 1'b1;
    idle(1);
    jabber = 1'b0;
    rd(0, phy_addr, PLS_REG_STATUS, 16'h784D);
    quiet = 1'b1;
    i_mgmt.frame(0, PLS_OP_WRITE, phy_addr, PLS_REG_STATUS, 16'($urandom));
    rd(0, phy_addr ^ 5'h01, PLS_REG_STATUS, 16'hFFFF);
    quiet = 1'b0;
    rd(0, phy_addr, PLS_REG_STATUS, 16'h784D);
    rd(0, phy_addr, 5'($urandom_range(31, 2)), 16'h0000);
    i_mgmt.bit_cycle(1'b1, 1'b0, s);
    i_mgmt.bit_cycle(1'b1, 1'b0, s);
    rd(1, phy_addr, PLS_REG_STATUS, 16'h784D);
    for (int k = 0; k < 6; k++)
    begin
      a = $urandom;
      an_enable = a[0] | (k < 2);
      an_complete = (a[1] | (k == 0)) & (k != 1);
      idle(2);
      rd(0, phy_addr, PLS_REG_STATUS, 16'h784D | {10'h000, an_enable & an_complete, 5'h00});
    end
    idle(20);
    if (exp_q.size() != 0)
      fails++;
    summarize();
  end
endmodule : tb_top
